// >>> logic/tws_pkg.sv
// Shared constants for the two-wire configuration slave and its host
package tws_pkg;
    // ----------------------------------------
    // Bus addressing
    // ----------------------------------------
    localparam logic [5:0] TWS_ADDR_HI = 6'h26;
    localparam int TWS_FILT_DEPTH = 3;
    // Quarter SCL phase in mclk cycles; must outlast the slave's filter lag
    localparam int TWS_DIV_HALF = 52;
    localparam logic TWS_DIR_READ = 1'b1;
    localparam logic TWS_DIR_WRITE = 1'b0;
    localparam logic [7:0] TWS_PTR_RST = 8'h00;
    localparam logic [3:0] TWS_BIT_RST = 4'h0;
    localparam logic [3:0] TWS_BIT_ACK = 4'h8;

    typedef enum logic [2:0] {
        TWS_S_IDLE = 3'b000,
        TWS_S_ADDR = 3'b001,
        TWS_S_PTR = 3'b010,
        TWS_S_WDATA = 3'b011,
        TWS_S_RDATA = 3'b100,
        TWS_S_SKIP = 3'b101
    } tws_slv_state_t;

    typedef enum logic [2:0] {
        TWS_H_IDLE = 3'b000,
        TWS_H_START = 3'b001,
        TWS_H_BIT = 3'b010,
        TWS_H_ACK = 3'b011,
        TWS_H_STOP = 3'b100,
        TWS_H_RSTART = 3'b101
    } tws_hst_state_t;
endpackage : tws_pkg

// >>> logic/tws_if.sv
// Two-wire link between host and configuration slave
`timescale 1ns/1ps
interface tws_if;
    logic scl_o;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl_i;
    logic sda_i;
    // SDA is an open-drain wired AND, idle high through the pull-up; SCL is driven by the host alone
    assign scl_i = scl_o;
    assign sda_i = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
    modport host (output scl_o, output sda_host_o, output sda_host_oe,
        input sda_i);
    modport dev (input scl_i, input sda_i, output sda_dev_o,
        output sda_dev_oe);
endinterface : tws_if

// >>> logic/tws_slave.sv
// Two-wire configuration slave, device end
// Function
// - Host clocks; data line is open drain.
// - Address 100110 plus strap bit.
// - Idle high; start is SDA falls, SCL high.
// - Ignore everything until a start.
// - Host sends address then direction bit.
// - Acknowledge match on ninth clock only.
// - Stop or repeated start ends transfer.
// - Host holds data stable while SCL high.
// - SCL filtered, delayed three reference clocks.
// - Sample data on filtered SCL rise.
// - Read data changes after filtered SCL fall.
// - First write byte loads the pointer.
// - Pointer increments after each written byte.
// - Read: write pointer, repeated start, read.
// - Reads return pointed register, then increment.
// - Slave stays active during standby.
`timescale 1ns/1ps
module tws_slave
    import tws_pkg::*;
(
    input wire logic link_clk,
    input wire logic sys_rst,
    input wire logic addr_strap,
    tws_if.dev bus,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // ----------------------------------------
    // Synchronisers and SCL filter
    // ----------------------------------------
    logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
    logic [TWS_FILT_DEPTH-1:0] filt_q, filt_d;
    logic scl_f_q, scl_f_d, sda_p_q, sda_p_d;
    logic [1:0] rst_sync_q, rst_sync_d, strap_sync_q, strap_sync_d;
    logic [6:0] own_addr;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_sync_d = {scl_sync_q[0], bus.scl_i};
        sda_sync_d = {sda_sync_q[0], bus.sda_i};
        filt_d = {filt_q[TWS_FILT_DEPTH-2:0], scl_sync_q[1]};
        scl_f_d = scl_f_q;
        if (&filt_q) begin
            scl_f_d = 1'b1;
        end else if (~|filt_q) begin
            scl_f_d = 1'b0;
        end
        sda_p_d = sda_sync_q[1];
        rst_sync_d = {rst_sync_q[0], sys_rst};
        strap_sync_d = {strap_sync_q[0], addr_strap};
    end

    // Reset comes from the system clock domain, so it is resynchronised
    always_ff @(posedge link_clk) begin
        rst_sync_q <= rst_sync_d;
        strap_sync_q <= strap_sync_d;
        scl_sync_q <= scl_sync_d;
        sda_sync_q <= sda_sync_d;
        filt_q <= filt_d;
        scl_f_q <= scl_f_d;
        sda_p_q <= sda_p_d;
    end

    assign scl_rise = scl_f_d & ~scl_f_q;
    assign scl_fall = ~scl_f_d & scl_f_q;
    assign start_det = scl_f_q & sda_p_q & ~sda_sync_q[1];
    assign stop_det = scl_f_q & ~sda_p_q & sda_sync_q[1];
    assign own_addr = {TWS_ADDR_HI, strap_sync_q[1]};

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    tws_slv_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wd_q, wd_d;
    logic ack_q, ack_d, oe_q, oe_d, dout_q, dout_d;
    logic wr_q, wr_d, rd_q, rd_d;

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        wd_d = wd_q;
        ack_d = ack_q;
        oe_d = oe_q;
        dout_d = dout_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        // Step after the write strobe, so the strobe sees the old address
        if (wr_q) begin
            ptr_d = ptr_q + 8'h01;
        end
        if (start_det) begin
            st_d = TWS_S_ADDR;
            bit_d = TWS_BIT_RST;
            oe_d = 1'b0;
            ack_d = 1'b0;
        end else if (stop_det) begin
            st_d = TWS_S_IDLE;
            oe_d = 1'b0;
        end else if (scl_rise) begin
            case (st_q)
                TWS_S_IDLE, TWS_S_SKIP: begin
                end
                default: begin
                    if (bit_q == TWS_BIT_ACK) begin
                        // Master ack on a read: nack ends the burst
                        if (st_q == TWS_S_RDATA && sda_sync_q[1]) begin
                            st_d = TWS_S_SKIP;
                        end
                        bit_d = TWS_BIT_RST;
                    end else begin
                        sh_d = {sh_q[6:0], sda_sync_q[1]};
                        bit_d = bit_q + 4'h1;
                    end
                end
            endcase
        end else if (scl_fall) begin
            oe_d = 1'b0;
            dout_d = 1'b1;
            if (bit_q == TWS_BIT_ACK && !ack_q) begin
                ack_d = 1'b1;
                case (st_q)
                    TWS_S_ADDR: begin
                        if (sh_q[7:1] == own_addr) begin
                            oe_d = 1'b1;
                            dout_d = 1'b0;
                            if (sh_q[0] == TWS_DIR_READ) begin
                                st_d = TWS_S_RDATA;
                                rd_d = 1'b1;
                            end else begin
                                st_d = TWS_S_PTR;
                            end
                        end else begin
                            st_d = TWS_S_SKIP;
                        end
                    end
                    TWS_S_PTR: begin
                        ptr_d = sh_q;
                        oe_d = 1'b1;
                        dout_d = 1'b0;
                        st_d = TWS_S_WDATA;
                    end
                    TWS_S_WDATA: begin
                        wd_d = sh_q;
                        wr_d = 1'b1;
                        oe_d = 1'b1;
                        dout_d = 1'b0;
                    end
                    default: begin
                    end
                endcase
            end else if (bit_q == TWS_BIT_RST && ack_q) begin
                ack_d = 1'b0;
                if (st_q == TWS_S_RDATA) begin
                    sh_d = reg_rdata;
                end
            end else if (bit_q == TWS_BIT_ACK && ack_q) begin
                ack_d = 1'b0;
            end
            if (st_q == TWS_S_RDATA && bit_q != TWS_BIT_ACK) begin
                // Drive only zeros; a one is a release
                oe_d = ~sh_d[7];
                dout_d = 1'b0;
            end
            if (st_q == TWS_S_RDATA && bit_q == TWS_BIT_ACK) begin
                // Ack flag stays set so the next fall loads the next byte
                ptr_d = ptr_q + 8'h01;
                rd_d = 1'b1;
            end
        end
        if (rst_sync_q[1]) begin
            st_d = TWS_S_IDLE;
            bit_d = TWS_BIT_RST;
            ptr_d = TWS_PTR_RST;
            sh_d = 8'h00;
            ack_d = 1'b0;
            oe_d = 1'b0;
            dout_d = 1'b1;
        end
    end

    // Runs on the link clock only, so standby gating elsewhere spares it
    always_ff @(posedge link_clk) begin
        st_q <= st_d;
        bit_q <= bit_d;
        sh_q <= sh_d;
        ptr_q <= ptr_d;
        wd_q <= wd_d;
        ack_q <= ack_d;
        oe_q <= oe_d;
        dout_q <= dout_d;
        wr_q <= wr_d;
        rd_q <= rd_d;
    end

    assign bus.sda_dev_oe = oe_q;
    assign bus.sda_dev_o = dout_q;
    assign reg_addr = ptr_q;
    assign reg_wdata = wd_q;
    assign reg_wr = wr_q;
    assign reg_rd = rd_q;
endmodule : tws_slave

// >>> logic/tws_host.sv
// Two-wire host end: issues register writes and reads
`timescale 1ns/1ps
module tws_host
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    tws_if.host bus,
    input wire logic req,
    input wire logic req_rd,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] req_reg,
    input wire logic [7:0] req_data,
    output logic busy,
    output logic done,
    output logic nack,
    output logic [7:0] rd_data
);
    // ----------------------------------------
    // Bit engine, quarter-period phases
    // ----------------------------------------
    tws_hst_state_t st_q, st_d;
    logic [7:0] div_q, div_d, sh_q, sh_d, rdd_q, rdd_d;
    logic [1:0] ph_q, ph_d, byte_q, byte_d, sdas_q, sdas_d;
    logic [3:0] bit_q, bit_d;
    logic scl_q, scl_d, sda_q, sda_d, busy_q, busy_d, done_q, done_d;
    logic nack_q, nack_d, rd_q, rd_d, tick;

    assign tick = (div_q == 8'(TWS_DIV_HALF - 1));

    always_comb begin
        st_d = st_q;
        div_d = tick ? 8'h00 : div_q + 8'h01;
        ph_d = tick ? ph_q + 2'h1 : ph_q;
        sh_d = sh_q;
        rdd_d = rdd_q;
        byte_d = byte_q;
        bit_d = bit_q;
        scl_d = scl_q;
        sda_d = sda_q;
        busy_d = busy_q;
        done_d = 1'b0;
        nack_d = nack_q;
        rd_d = rd_q;
        sdas_d = {sdas_q[0], bus.sda_i};
        case (st_q)
            TWS_H_IDLE: begin
                scl_d = 1'b1;
                sda_d = 1'b1;
                if (req) begin
                    st_d = TWS_H_START;
                    rd_d = req_rd;
                    sh_d = {dev_addr, TWS_DIR_WRITE};
                    byte_d = 2'd0;
                    busy_d = 1'b1;
                    nack_d = 1'b0;
                    ph_d = 2'd0;
                    div_d = 8'h00;
                end
            end
            TWS_H_START, TWS_H_RSTART: begin
                if (tick) begin
                    case (ph_q)
                        2'd0: begin
                            sda_d = 1'b1;
                        end
                        2'd1: begin
                            scl_d = 1'b1;
                        end
                        2'd2: begin
                            sda_d = 1'b0;
                        end
                        default: begin
                            scl_d = 1'b0;
                            st_d = TWS_H_BIT;
                            bit_d = 4'h0;
                        end
                    endcase
                end
            end
            TWS_H_BIT, TWS_H_ACK: begin
                if (tick) begin
                    case (ph_q)
                        2'd0: begin
                            // Data changes only with SCL low
                            if (st_q == TWS_H_BIT) begin
                                sda_d = (byte_q == 2'd3) ? 1'b1 : sh_q[7];
                            end else begin
                                // Released for the slave ack or our nack
                                sda_d = 1'b1;
                            end
                        end
                        2'd1: begin
                            scl_d = 1'b1;
                        end
                        2'd2: begin
                            if (st_q == TWS_H_BIT) begin
                                sh_d = {sh_q[6:0], sdas_q[1]};
                            end else if (byte_q != 2'd3 && sdas_q[1]) begin
                                nack_d = 1'b1;
                            end
                        end
                        default: begin
                            scl_d = 1'b0;
                            if (st_q == TWS_H_BIT) begin
                                bit_d = bit_q + 4'h1;
                                if (bit_q == 4'h7) begin
                                    st_d = TWS_H_ACK;
                                end
                            end else if (nack_q || byte_q == 2'd3) begin
                                if (byte_q == 2'd3) begin
                                    rdd_d = sh_q;
                                end
                                st_d = TWS_H_STOP;
                            end else begin
                                bit_d = 4'h0;
                                st_d = TWS_H_BIT;
                                case (byte_q)
                                    2'd0: begin
                                        byte_d = 2'd1;
                                        sh_d = req_reg;
                                    end
                                    2'd1: begin
                                        byte_d = 2'd2;
                                        if (rd_q) begin
                                            st_d = TWS_H_RSTART;
                                            sh_d = {dev_addr, TWS_DIR_READ};
                                        end else begin
                                            sh_d = req_data;
                                        end
                                    end
                                    2'd2: begin
                                        if (rd_q) begin
                                            // Address acked; now receive
                                            byte_d = 2'd3;
                                            sh_d = 8'hff;
                                        end else begin
                                            st_d = TWS_H_STOP;
                                        end
                                    end
                                    default: begin
                                        st_d = TWS_H_STOP;
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tick) begin
                    case (ph_q)
                        2'd0: begin
                            sda_d = 1'b0;
                        end
                        2'd1: begin
                            scl_d = 1'b1;
                        end
                        2'd2: begin
                            sda_d = 1'b1;
                        end
                        default: begin
                            st_d = TWS_H_IDLE;
                            busy_d = 1'b0;
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
        endcase
        if (sys_rst) begin
            st_d = TWS_H_IDLE;
            div_d = 8'h00;
            ph_d = 2'd0;
            scl_d = 1'b1;
            sda_d = 1'b1;
            busy_d = 1'b0;
            nack_d = 1'b0;
            bit_d = 4'h0;
            byte_d = 2'd0;
        end
    end

    always_ff @(posedge mclk) begin
        st_q <= st_d;
        div_q <= div_d;
        ph_q <= ph_d;
        sh_q <= sh_d;
        rdd_q <= rdd_d;
        byte_q <= byte_d;
        bit_q <= bit_d;
        scl_q <= scl_d;
        sda_q <= sda_d;
        busy_q <= busy_d;
        done_q <= done_d;
        nack_q <= nack_d;
        rd_q <= rd_d;
        sdas_q <= sdas_d;
    end

    assign bus.scl_o = scl_q;
    assign bus.sda_host_o = sda_q;
    assign bus.sda_host_oe = ~sda_q;
    assign busy = busy_q;
    assign done = done_q;
    assign nack = nack_q;
    assign rd_data = rdd_q;
endmodule : tws_host

// >>> sim/tws_checker.sv
// Assertions on the two-wire link between host and slave
`timescale 1ns/1ps
module tws_checker
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic link_clk,
    input wire logic sys_rst,
    input wire logic scl_o,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl_i,
    input wire logic sda_i
);
    // ----------------------------------------
    // Clock rises since the last start
    // ----------------------------------------
    logic scl_q;
    logic sda_q;
    logic start_w;
    logic [3:0] rise_d;
    logic [3:0] rise_q;

    assign start_w = scl_q & scl_i & sda_q & ~sda_i;

    always_comb begin
        rise_d = rise_q;
        if (start_w) begin
            rise_d = 4'h0;
        end else if (scl_i & ~scl_q & (rise_q != 4'hf)) begin
            rise_d = rise_q + 4'h1;
        end
    end

    // Saturates so that only the address byte is policed
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rise_q <= 4'hf;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            rise_q <= rise_d;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_start;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence

    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence

    property p_host_od;
        @(posedge mclk) disable iff (sys_rst) sda_host_oe |-> !sda_host_o;
    endproperty
    property p_dev_od;
        @(posedge link_clk) disable iff (sys_rst) sda_dev_oe |-> !sda_dev_o;
    endproperty
    property p_idle_high;
        @(posedge mclk) disable iff (sys_rst) $fell(sys_rst) |-> scl_i && sda_i;
    endproperty
    property p_host_hold;
        @(posedge mclk) disable iff (sys_rst)
            $fell(scl_o) |-> $stable(sda_host_oe & ~sda_host_o);
    endproperty
    property p_start_clk;
        @(posedge mclk) disable iff (sys_rst) s_start |-> ##[1:64] !scl_o;
    endproperty
    property p_addr_quiet;
        @(posedge mclk) disable iff (sys_rst)
            $rose(scl_i) && (rise_q < 4'h8) |-> !sda_dev_oe;
    endproperty
    property p_dev_scl_low;
        @(posedge link_clk) disable iff (sys_rst) $rose(sda_dev_oe) |-> !scl_i;
    endproperty
    property p_stop_free;
        @(posedge mclk) disable iff (sys_rst) s_stop |-> (!sda_dev_oe) [*8];
    endproperty

    a_host_od: assert property (p_host_od)
        else $error("host drives data line high");
    a_dev_od: assert property (p_dev_od)
        else $error("slave drives data line high");
    a_idle_high: assert property (p_idle_high)
        else $error("lines not idle high after reset");
    a_host_hold: assert property (p_host_hold)
        else $error("host data changed at clock fall");
    a_start_clk: assert property (p_start_clk)
        else $error("no clock low after start");
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("slave drove during address bits");
    a_dev_scl_low: assert property (p_dev_scl_low)
        else $error("slave pulled data while clock high");
    a_stop_free: assert property (p_stop_free)
        else $error("slave on bus after stop");
endmodule : tws_checker

// >>> sim/two_wire_config_slave_tb.sv
// Bench joining the two-wire host and configuration slave
`timescale 1ns/1ps
module two_wire_config_slave_tb;
    import tws_pkg::*;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req = 1'b0;
    logic req_rd = 1'b0;
    logic [6:0] dev_addr = 7'h00;
    logic [7:0] req_reg = 8'h00;
    logic [7:0] req_data = 8'h00;
    logic addr_strap = 1'b0;
    logic busy, done, nack, reg_wr, reg_rd;
    logic [7:0] rd_data, reg_addr, reg_wdata, reg_rdata, last_wa, last_wd;
    logic [7:0] mon_sh;
    logic [3:0] mon_cnt = 4'h8;
    logic scl_p = 1'b1;
    logic sda_p = 1'b1;
    logic [7:0] regs [256];
    int wr_cnt = 0;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;

    // ----------------------------------------
    // Clocks, link and design ends
    // ----------------------------------------
    always #4 mclk = ~mclk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end

    tws_if u_tws_if ();
    tws_host u_tws_host (.mclk(mclk), .sys_rst(sys_rst),
        .bus(u_tws_if.host), .req(req), .req_rd(req_rd),
        .dev_addr(dev_addr), .req_reg(req_reg), .req_data(req_data),
        .busy(busy), .done(done), .nack(nack), .rd_data(rd_data));
    tws_slave u_tws_slave (.link_clk(link_clk), .sys_rst(sys_rst),
        .addr_strap(addr_strap), .bus(u_tws_if.dev), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    tws_checker u_tws_checker (.mclk(mclk), .link_clk(link_clk),
        .sys_rst(sys_rst), .scl_o(u_tws_if.scl_o),
        .sda_host_o(u_tws_if.sda_host_o),
        .sda_host_oe(u_tws_if.sda_host_oe),
        .sda_dev_o(u_tws_if.sda_dev_o), .sda_dev_oe(u_tws_if.sda_dev_oe),
        .scl_i(u_tws_if.scl_i), .sda_i(u_tws_if.sda_i));

    // Register file behind the slave, read combinationally
    assign reg_rdata = regs[reg_addr];
    always @(posedge link_clk) begin
        if (reg_wr === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
            last_wa <= reg_addr;
            last_wd <= reg_wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end

    // Wire monitor: first byte after every start, MSB first
    always @(posedge mclk) begin
        scl_p <= u_tws_if.scl_i;
        sda_p <= u_tws_if.sda_i;
        if (scl_p && u_tws_if.scl_i && sda_p && !u_tws_if.sda_i) begin
            mon_cnt <= 4'h0;
        end else if (!scl_p && u_tws_if.scl_i && mon_cnt < 4'h8) begin
            mon_sh <= {mon_sh[6:0], u_tws_if.sda_i};
            mon_cnt <= mon_cnt + 4'h1;
        end
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_idle();
        check("idle", {6'h00, u_tws_if.scl_i, u_tws_if.sda_i}, 8'h03);
    endtask : check_idle

    task automatic do_reset();
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge link_clk);
        @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge link_clk);
        #1;
        check("pointer", reg_addr, TWS_PTR_RST);
        check("busy", {7'h00, busy}, 8'h00);
        check_idle();
    endtask : do_reset

    task automatic xfer(input logic rd, input logic [6:0] a,
        input logic [7:0] r, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= 1'b1;
        req_rd <= rd;
        dev_addr <= a;
        req_reg <= r;
        req_data <= d;
        @(posedge mclk);
        req <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 12000);
        if (n >= 12000) begin
            fail_count++;
            report_and_stop();
        end
        // Let the slave's delayed clock finish the last bit
        repeat (8) @(posedge link_clk);
        #1;
    endtask : xfer

    task automatic do_write(input logic [6:0] a, input logic [7:0] r,
        input logic [7:0] d, input logic ack);
        int c;
        c = wr_cnt;
        xfer(1'b0, a, r, d);
        check("nack", {7'h00, nack}, {7'h00, ~ack});
        check("addr byte", mon_sh, {a, 1'b0});
        check("writes", 8'(wr_cnt - c), {7'h00, ack});
        if (ack) begin
            check("write addr", last_wa, r);
            check("write data", last_wd, d);
            check("pointer", reg_addr, r + 8'h01);
        end
        check_idle();
    endtask : do_write

    task automatic do_read(input logic [6:0] a, input logic [7:0] r,
        input logic [7:0] exp);
        xfer(1'b1, a, r, 8'h00);
        check("nack", {7'h00, nack}, 8'h00);
        check("addr byte", mon_sh, {a, 1'b1});
        check("read data", rd_data, exp);
        check("pointer", reg_addr, r + 8'h01);
        check_idle();
    endtask : do_read

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [6:0] own;
        int c;
        foreach (regs[i]) regs[i] = 8'h00;
        do_reset();
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            addr_strap <= s[0];
            own = {TWS_ADDR_HI, s[0]};
            do_write(own, 8'h3c + 8'(s), 8'hc4, 1'b1);
            do_write({TWS_ADDR_HI, ~s[0]}, 8'h50, 8'h11, 1'b0);
            do_write(7'h0c, 8'h50, 8'h11, 1'b0);
            do_read(own, 8'h3c + 8'(s), 8'hc4);
        end
        do_write(own, 8'hff, 8'h5a, 1'b1);
        do_write(own, 8'h00, 8'ha1, 1'b1);
        do_read(own, 8'hff, 8'h5a);
        do_read(own, 8'h00, 8'ha1);
        // Reset lands inside the data byte of a write
        c = wr_cnt;
        @(posedge mclk);
        dev_addr <= own;
        req_rd <= 1'b0;
        req_reg <= 8'h77;
        req_data <= 8'h99;
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        repeat (4500) @(posedge mclk);
        do_reset();
        check("aborted writes", 8'(wr_cnt - c), 8'h00);
        do_write(own, 8'h20, 8'h0f, 1'b1);
        do_read(own, 8'h20, 8'h0f);
        report_and_stop();
    end
endmodule : two_wire_config_slave_tb
